//--- core/clk_tree_dev.sv
/*
  Device end: shared modulator clock, sample strobe and continuous data clock,
  set by straps in pin mode or by two registers in serial mode.
  Assumes link inputs are synchronous to core_clk.
*/
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module clk_tree_dev (
  input  wire logic       core_clk,
  input  wire logic       srst,
  clk_tree_if.dev         lnk,
  output logic            mod_clk_en,
  output logic            sample_en,
  output logic            output_data_clock,
  output logic [1:0]      pwr_mode_out
);

  logic [7:0]             pwr_cfg_r;
  logic [7:0]             output_data_clock_cfg_r;
  logic [1:0]             pwr_sel;
  logic [1:0]             mod_sel;
  logic [1:0]             output_data_clock_sel;
  logic [5:0]             mod_div;
  logic [3:0]             data_clock_divider_select;
  logic [clk_tree_pkg::CNT_W-1:0] mod_cnt_r;
  logic [2:0]             output_data_clock_cnt_r;

  function automatic logic [5:0] mod_ratio(input logic [1:0] sel);
    case (sel)
      clk_tree_pkg::MOD_DIV_4: mod_ratio = 6'h04;
      clk_tree_pkg::MOD_DIV_8: mod_ratio = 6'h08;
      default:                 mod_ratio = 6'h20;
    endcase
  endfunction

  // Registers: serial mode configuration
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwr_cfg_r  <= clk_tree_pkg::PWR_MOD_CFG_RST;
      output_data_clock_cfg_r <= clk_tree_pkg::DATA_CLK_CFG_RST;
    end else if (lnk.reg_wr) begin
      if (lnk.reg_addr == clk_tree_pkg::PWR_MOD_CFG_OFS)
        pwr_cfg_r <= lnk.reg_wdata;
      if (lnk.reg_addr == clk_tree_pkg::DATA_CLK_CFG_OFS)
        output_data_clock_cfg_r <= lnk.reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lnk.reg_ack   <= 1'b0;
      lnk.reg_rdata <= 8'h00;
    end else begin
      lnk.reg_ack <= (lnk.reg_wr | lnk.reg_rd) & ~lnk.reg_ack;
      case (lnk.reg_addr)
        clk_tree_pkg::PWR_MOD_CFG_OFS:  lnk.reg_rdata <= pwr_cfg_r;
        clk_tree_pkg::DATA_CLK_CFG_OFS: lnk.reg_rdata <= output_data_clock_cfg_r;
        clk_tree_pkg::STATUS_OFS:       lnk.reg_rdata <= {lnk.pin_mode, 3'h0, output_data_clock_sel, pwr_sel};
        default:                        lnk.reg_rdata <= 8'h00;
      endcase
    end
  end

  // Selection: straps in pin mode, registers otherwise
  always_comb begin
    if (lnk.pin_mode) begin
      pwr_sel  = lnk.strap_mode_pins[1:0];
      mod_sel  = lnk.strap_mode_pins[1:0];
      output_data_clock_sel = lnk.strap_mode_pins[3:2];
    end else begin
      pwr_sel  = pwr_cfg_r[clk_tree_pkg::PWR_MODE_LSB +: 2];
      mod_sel  = pwr_cfg_r[clk_tree_pkg::MOD_DIV_LSB +: 2];
      output_data_clock_sel = output_data_clock_cfg_r[clk_tree_pkg::OUTPUT_DATA_CLOCK_SEL_LSB +: 2];
    end
  end

  assign mod_div  = mod_ratio(mod_sel);
  assign data_clock_divider_select = 4'h8 >> output_data_clock_sel;

  // One counter for all channels, so every channel sees the same instants
  always_ff @(posedge core_clk) begin
    if (srst)
      mod_cnt_r <= '0;
    else if ({1'b0, mod_cnt_r} >= mod_div - 6'h01)
      mod_cnt_r <= '0;
    else
      mod_cnt_r <= mod_cnt_r + 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mod_clk_en <= 1'b0;
      sample_en  <= 1'b0;
    end else begin
      mod_clk_en <= (mod_cnt_r == '0);
      sample_en  <= (mod_cnt_r == '0) ||
                    ({1'b0, mod_cnt_r} == {1'b0, mod_div[5:1]});
    end
  end

  // Free running; divide by one passes a toggling level at half rate per edge pair
  always_ff @(posedge core_clk) begin
    if (srst) begin
      output_data_clock_cnt_r        <= 3'h0;
      output_data_clock <= 1'b0;
    end else begin
      if ({1'b0, output_data_clock_cnt_r} >= (data_clock_divider_select >> 1) - 4'h1 || data_clock_divider_select == 4'h1) begin
        output_data_clock_cnt_r        <= 3'h0;
        output_data_clock <= ~output_data_clock;
      end else begin
        output_data_clock_cnt_r <= output_data_clock_cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst)
      pwr_mode_out <= 2'h0;
    else
      pwr_mode_out <= pwr_sel;
  end

endmodule // clk_tree_dev

//--- core/clk_tree_host.sv
/*
  Host end: drives straps and mode select, and forwards single register
  writes and reads from its classic Wishbone slave port.
  Assumes the device answers each access with a one-cycle ack.
*/
`timescale 1ns/1ps
module clk_tree_host (
  input  wire logic       core_clk,
  input  wire logic       srst,
  clk_tree_if.host        lnk,
  input  wire logic       use_pin_mode,
  input  wire logic [3:0] strap_value,
  input  wire logic       wb_cyc,
  input  wire logic       wb_stb,
  input  wire logic       wb_we,
  input  wire logic       wb_sel,
  input  wire logic [7:0] wb_adr,
  input  wire logic [7:0] wb_dat_w,
  output logic            busy,
  output logic            wb_ack,
  output logic [7:0]      wb_dat_r
);

  typedef enum logic [1:0] {IDLE = 2'b01, WAIT = 2'b10} hst_state_t;
  hst_state_t state_r;

  // Straps held as levels; host keeps them legal for the supplied clock
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lnk.pin_mode        <= 1'b1;
      lnk.strap_mode_pins <= 4'h0;
    end else begin
      lnk.pin_mode        <= use_pin_mode;
      lnk.strap_mode_pins <= strap_value;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r       <= IDLE;
      lnk.reg_wr    <= 1'b0;
      lnk.reg_rd    <= 1'b0;
      lnk.reg_addr  <= 8'h00;
      lnk.reg_wdata <= 8'h00;
      busy          <= 1'b0;
      wb_ack        <= 1'b0;
      wb_dat_r      <= 8'h00;
    end else begin
      wb_ack <= 1'b0;
      case (state_r)
        IDLE: begin
          // Ack still seen by the master this cycle: must not start again
          if (wb_cyc && wb_stb && !wb_ack) begin
            // A write with no byte selected becomes a harmless read
            lnk.reg_wr    <= wb_we & wb_sel;
            lnk.reg_rd    <= ~(wb_we & wb_sel);
            lnk.reg_addr  <= wb_adr;
            lnk.reg_wdata <= wb_dat_w;
            busy          <= 1'b1;
            state_r       <= WAIT;
          end
        end
        WAIT: begin
          if (lnk.reg_ack) begin
            lnk.reg_wr <= 1'b0;
            lnk.reg_rd <= 1'b0;
            wb_dat_r   <= lnk.reg_rdata;
            busy       <= 1'b0;
            wb_ack     <= 1'b1;
            state_r    <= IDLE;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

endmodule // clk_tree_host

//--- core/clk_tree_if.sv
/*
  Link between the clock tree device and its configuring host: straps,
  control mode select and an 8-bit register port.
  Assumes both ends run on the same core_clk.
*/
`timescale 1ns/1ps
interface clk_tree_if;
  logic       pin_mode;
  logic [3:0] strap_mode_pins;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_ack;

  modport dev (input pin_mode, strap_mode_pins, reg_wr, reg_rd, reg_addr, reg_wdata,
               output reg_rdata, reg_ack);
  modport host (output pin_mode, strap_mode_pins, reg_wr, reg_rd, reg_addr, reg_wdata,
                input reg_rdata, reg_ack);
endinterface

//--- core/clk_tree_pkg.sv
/*
  Constants shared by the clock tree device end and its configuring host end:
  register offsets, field positions, divider and power mode encodings.
  Assumes one master clock, core_clk, drives both ends.
*/
// Functional notes
// - Sample strobe twice per modulator clock period
// - All channels share one master clock
// - Derived clocks synchronous to master clock
// - Modulator divider: four, eight, thirty-two
// - Settings apply to all channels
// - Host keeps modulator rate within mode range
// - Pin mode: divider follows power mode
// - Pin mode: straps alone set everything
// - Serial mode: two registers set everything
// - Serial mode: power and divider independent
// - Fastest rate: 32.768 MHz, divide four
// - Data clock divider: one, two, four, eight; divide by one gives the same rate as divide by two
// - Data clock toggles continuously, never gated
// - Host picks lanes to fit 32-bit words
// - Host supplies master clock from valid source
// - Divider/decimation trade only in serial mode
package clk_tree_pkg;

  localparam logic [7:0] PWR_MOD_CFG_OFS  = 8'h04;
  localparam logic [7:0] DATA_CLK_CFG_OFS = 8'h07;
  localparam logic [7:0] STATUS_OFS       = 8'h08;

  // power_and_modulator_clock_config: [5:4] power mode, [1:0] modulator divider
  localparam int PWR_MODE_LSB = 4;
  localparam int MOD_DIV_LSB  = 0;
  // data_clock_config: [1:0] data clock divider select
  localparam int OUTPUT_DATA_CLOCK_SEL_LSB = 0;

  localparam logic [7:0] PWR_MOD_CFG_RST  = 8'h00;
  localparam logic [7:0] DATA_CLK_CFG_RST = 8'h00;

  typedef enum logic [1:0] {
    PWR_ECO    = 2'h0,
    PWR_MEDIAN = 2'h2,
    PWR_FAST   = 2'h3
  } pwr_mode_t;

  typedef enum logic [1:0] {
    MOD_DIV_32 = 2'h0,
    MOD_DIV_8  = 2'h2,
    MOD_DIV_4  = 2'h3
  } mod_div_t;

  localparam logic [1:0] DATA_CLOCK_DIVIDER_SELECT_8 = 2'h0;
  localparam logic [1:0] DATA_CLOCK_DIVIDER_SELECT_4 = 2'h1;
  localparam logic [1:0] DATA_CLOCK_DIVIDER_SELECT_2 = 2'h2;
  localparam logic [1:0] DATA_CLOCK_DIVIDER_SELECT_1 = 2'h3;

  localparam int CNT_W = 5;

endpackage

//--- tb/adc_clock_tree_power_scaling_test.sv
/* Self-checking bench joining device and host ends through clk_tree_if.
   Assumes a single 20 MHz core_clk and synchronous active-high srst. */
`timescale 1ns/1ps
module adc_clock_tree_power_scaling_test;
  logic       core_clk, srst, use_pin_mode, wb_cyc, wb_stb, wb_we, wb_sel, busy, wb_ack;
  logic       mod_clk_en, sample_en, output_data_clock;
  logic [1:0] pwr_mode_out;
  logic [3:0] strap_value;
  logic [7:0] wb_adr, wb_dat_w, wb_dat_r, v;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic [1:0] code[3] = '{2'h0, 2'h2, 2'h3};
  int         per[3] = '{32, 8, 4};
  int         half[4] = '{4, 2, 1, 1};
  int         errors, comparisons, seed;
  clk_tree_if lnk ();
  clk_tree_dev clk_tree_dev_inst (.core_clk(core_clk), .srst(srst), .lnk(lnk),
    .mod_clk_en(mod_clk_en), .sample_en(sample_en), .output_data_clock(output_data_clock),
    .pwr_mode_out(pwr_mode_out));
  clk_tree_host clk_tree_host_inst (.core_clk(core_clk), .srst(srst), .lnk(lnk),
    .use_pin_mode(use_pin_mode), .strap_value(strap_value), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_sel(wb_sel), .wb_adr(wb_adr),
    .wb_dat_w(wb_dat_w), .busy(busy), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r));
  clk_tree_monitor clk_tree_monitor_inst (.core_clk(core_clk), .srst(srst),
    .pin_mode(lnk.pin_mode), .strap_mode_pins(lnk.strap_mode_pins), .reg_wr(lnk.reg_wr),
    .reg_rd(lnk.reg_rd), .reg_addr(lnk.reg_addr), .reg_ack(lnk.reg_ack),
    .mod_clk_en(mod_clk_en), .sample_en(sample_en), .output_data_clock(output_data_clock),
    .pwr_mode_out(pwr_mode_out));
  task automatic tally(input bit ok, input string what);
    comparisons++;
    if (!ok) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task automatic cmp_data(input logic [7:0] got, input logic [7:0] x);
    tally(got === x, $sformatf("read data %h expected %h", got, x));
  endtask
  task automatic cmp_count(input int got, input int x);
    tally(got == x, $sformatf("count %0d expected %0d", got, x));
  endtask
  task automatic cmp_mode(input logic [1:0] got, input logic [1:0] x);
    tally(got === x, $sformatf("power mode %h expected %h", got, x));
  endtask
  task automatic cmp_flag(input logic got, input logic x);
    tally(got === x, $sformatf("flag %b expected %b", got, x));
  endtask
  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Writes queue only the busy check; reads also queue the expected value
  // Request held until ack is sampled high; there is no timeout, so only the watchdog ends a wait that never sees ack
  task automatic acc(input logic we, input logic [7:0] a, d, x);
    exp_q.push_back({!we, x});
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 1'b1;
    wb_adr <= a;
    wb_dat_w <= d;
    do @(posedge core_clk); while (wb_ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // Second pass measures; the first only aligns to an edge or tick
  task automatic meas(input bit dck, input int x);
    logic lvl;
    int c;
    int s;
    repeat (70) @(negedge core_clk);
    for (int k = 0; k < 2; k++) begin
      lvl = output_data_clock;
      c = 0;
      s = 0;
      do begin
        @(negedge core_clk);
        c++;
        if (sample_en === 1'b1) s++;
      end while ((dck ? output_data_clock === lvl : mod_clk_en !== 1'b1) && c < 99);
    end
    cmp_count(c, x);
    if (!dck) cmp_count(s, 2);
  endtask
  always @(negedge core_clk) if (wb_ack === 1'b1 && exp_q.size() > 0) begin
    e = exp_q.pop_front();
    cmp_flag(busy, 1'b0);
    if (e[8]) cmp_data(wb_dat_r, e[7:0]);
  end
  // Bench clock stands in for the externally supplied master clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    stop_test;
  end
  initial begin
    srst = 1'b1;
    use_pin_mode = 1'b0;
    strap_value = 4'h0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_sel = 1'b0;
    wb_adr = 8'h00;
    wb_dat_w = 8'h00;
    seed = 32'hf8f4;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    acc(0, clk_tree_pkg::PWR_MOD_CFG_OFS, 8'h00, clk_tree_pkg::PWR_MOD_CFG_RST);
    acc(0, clk_tree_pkg::DATA_CLK_CFG_OFS, 8'h00, clk_tree_pkg::DATA_CLK_CFG_RST);
    for (int p = 0; p < 3; p++) for (int m = 0; m < 3; m++) begin
      v = {2'h0, code[p], 2'h0, code[m]};
      acc(1, clk_tree_pkg::PWR_MOD_CFG_OFS, v, 8'h00);
      acc(0, clk_tree_pkg::PWR_MOD_CFG_OFS, 8'h00, v);
      meas(0, per[m]);
      cmp_mode(pwr_mode_out, code[p]);
    end
    for (int d = 0; d < 4; d++) begin
      acc(1, clk_tree_pkg::DATA_CLK_CFG_OFS, 8'(d), 8'h00);
      acc(0, clk_tree_pkg::STATUS_OFS, 8'h00, {4'h0, 2'(d), 2'h3});
      meas(1, half[d]);
    end
    v = 8'($random(seed));
    acc(1, {4'h1, v[3:0]}, v, 8'h00);
    acc(0, {4'h1, v[3:0]}, 8'h00, 8'h00);
    use_pin_mode <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      @(posedge core_clk);
      strap_value <= {2'(m), code[m]};
      // Register write must not override the straps
      acc(1, clk_tree_pkg::PWR_MOD_CFG_OFS, 8'h33, 8'h00);
      meas(0, per[m]);
      meas(1, half[m]);
      cmp_mode(pwr_mode_out, code[m]);
    end
    stop_test;
  end
endmodule // adc_clock_tree_power_scaling_test

//--- tb/clk_tree_monitor.sv
/* Checker for the clock tree link and device clocks.
   Instantiated beside clk_tree_if; everything runs on core_clk. */
`timescale 1ns/1ps
module clk_tree_monitor (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       pin_mode,
  input wire logic [3:0] strap_mode_pins,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_ack,
  input wire logic       mod_clk_en,
  input wire logic       sample_en,
  input wire logic       output_data_clock,
  input wire logic [1:0] pwr_mode_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [5:0] hold_r;
  // Cycles since the data clock last moved; wrap after reconfig stays below 40
  always_ff @(posedge core_clk) begin
    if (srst) hold_r <= 6'h00;
    else hold_r <= $changed(output_data_clock) ? 6'h00 : hold_r + 6'h01;
  end
  sequence fast_pins; (pin_mode && strap_mode_pins[1:0] == 2'h3)[*8]; endsequence
  sequence quarter_gap; !mod_clk_en[*3] ##1 mod_clk_en; endsequence
  a_ack_timing: assert property ($rose(reg_wr | reg_rd) |=> reg_ack)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (reg_ack |=> !reg_ack)
    else $error("ack longer than one cycle");
  a_req_held: assert property (reg_wr && !reg_ack |=> reg_wr && $stable(reg_addr))
    else $error("write dropped before ack");
  a_sample_with_mod: assert property (mod_clk_en |-> sample_en)
    else $error("modulator tick without sample");
  a_mod_single: assert property (mod_clk_en |=> !mod_clk_en)
    else $error("modulator enable wider than one cycle");
  a_pin_power: assert property ((pin_mode && $stable(strap_mode_pins))[*4] ##0
    strap_mode_pins[1:0] != 2'h1 |-> pwr_mode_out == strap_mode_pins[1:0])
    else $error("power mode does not follow straps");
  a_fast_divide: assert property (fast_pins ##0 mod_clk_en |=> quarter_gap)
    else $error("fast strap not divide by four");
  a_output_data_clock_running: assert property (hold_r < 6'h28)
    else $error("data clock stopped");
endmodule // clk_tree_monitor
